// file: verilog/mdm_pkg.sv
// Shared constants and types for the serial management link ends
//
// Functional notes
// - Station clocks link at most 12.5 MHz when MDC_HALF is 4 or more
// - Legacy frame fields sent most significant first
// - Legacy turnaround: write 10, read z0
// - Port address fixed at reset; match only
// - Page field selects page for legacy registers
// - Page register reachable under any page
// - Ignore bits widen write address matching
// - Reads always match full port address
// - Station sets broadcast by four writes
// - Broadcast writes update all four ports
// - Clearing bit 14 ends broadcast writing
// - Hard reset clears page register; 13:8 zero
// - Start 01 legacy, start 00 extended
// - Extended opcodes and turnaround per type
// - Address frame loads extended address register
// - Read-increment advances address after read
// - Extended address register has no reset
// - Extended device 3 window maps legacy registers
// - Frames without preamble always accepted
// - Station leaves one idle bit between frames
// - Order strap sets low port address bits
// - Upper port address bits from strap only
package mdm_pkg;

   typedef logic [15:0] mdm_word_t;

   // =====================================================================
   // Timing
   localparam int CORE_HZ      = 100_000_000;
   localparam int MDC_MAX_HZ   = 12_500_000;
   localparam int MDC_HALF_MIN = (CORE_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);
   localparam logic [1:0] STRAP_WAIT = 2'h3;

   // =====================================================================
   // Frame layout
   localparam logic [1:0] ST_LEGACY   = 2'h1;
   localparam logic [1:0] ST_EXT      = 2'h0;
   localparam logic [1:0] OP_LEG_RD   = 2'h2;
   localparam logic [1:0] OP_LEG_WR   = 2'h1;
   localparam logic [1:0] OP_EXT_ADDR = 2'h0;
   localparam logic [1:0] OP_EXT_WR   = 2'h1;
   localparam logic [1:0] OP_EXT_RD   = 2'h3;
   localparam logic [1:0] OP_EXT_RDI  = 2'h2;
   localparam logic [1:0] TA_DRIVEN   = 2'h2;
   localparam logic [1:0] TA_RELEASED = 2'h3;
   localparam logic [4:0] HDR_LAST    = 5'hc;
   localparam logic [4:0] DATA_LAST   = 5'hf;
   localparam logic [6:0] PRE_BITS    = 7'h20;
   localparam logic [6:0] FRAME_BITS  = 7'h20;
   localparam logic [6:0] DATA_BITS   = 7'h10;
   localparam logic [6:0] TA_BITS     = 7'h2;

   // =====================================================================
   // Page register and legacy window
   localparam logic [4:0]  PAGE_REG_NUM   = 5'h16;
   localparam int          IGN_HI_BIT     = 15;
   localparam int          IGN_LO_BIT     = 14;
   localparam mdm_word_t   PAGE_REG_RST   = 16'h0000;
   localparam mdm_word_t   PAGE_REG_WMASK = 16'hc0ff;
   localparam logic [4:0]  LEG_DEVAD      = 5'h03;
   localparam logic [2:0]  LEG_WIN_TAG    = 3'h4;

   // =====================================================================
   // Station command registers (APB byte offsets)
   localparam logic [7:0] REG_FRAME   = 8'h00;
   localparam logic [7:0] REG_WDATA   = 8'h04;
   localparam logic [7:0] REG_STATUS  = 8'h08;
   localparam logic [7:0] REG_RDATA   = 8'h0c;
   localparam int         FRM_ST_LSB  = 0;
   localparam int         FRM_OP_LSB  = 2;
   localparam int         FRM_PA_LSB  = 4;
   localparam int         FRM_RA_LSB  = 9;
   localparam int         FRM_PRE_BIT = 14;
   localparam int         STS_BUSY    = 0;

endpackage

// file: verilog/mdm_if.sv
// Management link wires between station and device ends
`timescale 1ns/100ps
`default_nettype none
interface mdm_if;
   logic mdc;
   logic sta_mdio_o;
   logic sta_mdio_oe;
   logic dev_mdio_o;
   logic dev_mdio_oe;
   logic mdio;

   // Pulled-up line; any driver may pull low
   assign mdio = (~sta_mdio_oe | sta_mdio_o) & (~dev_mdio_oe | dev_mdio_o);

   modport station (output mdc, output sta_mdio_o, output sta_mdio_oe, input mdio);
   modport device  (input mdc, input mdio, output dev_mdio_o, output dev_mdio_oe);
endinterface
`default_nettype wire

// file: verilog/mdm_dev.sv
// Device end: four-port management slave with paging and broadcast writes
//
// The register access port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module mdm_dev (
   // Clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   rst_n,
   // Link
   mdm_if.device                       lnk,
   // Straps
   input  wire logic [2:0]             port_address_hi,
   input  wire logic                   port_address_order,
   // Register access
   output logic                        acc_wr,
   output logic                        acc_rd,
   output logic [3:0]                  acc_port_mask,
   output logic [4:0]                  acc_devad,
   output mdm_pkg::mdm_word_t          acc_regnum,
   output mdm_pkg::mdm_word_t          acc_wdata,
   input  wire mdm_pkg::mdm_word_t     acc_rdata,
   // Page state
   output mdm_pkg::mdm_word_t [3:0]    page_select_and_broadcast
);
   import mdm_pkg::*;

   typedef enum {S_IDLE, S_HDR, S_TA, S_DATA} mdm_dev_state_t;

   function automatic logic [1:0] mdm_low_addr(input logic [1:0] p, input logic order);
      return order ? ~p : p;
   endfunction

   function automatic logic [1:0] mdm_first(input logic [3:0] m);
      logic [1:0] r;
      r = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (m[i]) begin
            r = 2'(i);
         end
      end
      return r;
   endfunction

   // =====================================================================
   // Synchronisers
   logic [1:0] mdc_s_q;
   logic [1:0] mdio_s_q;
   logic       mdc_d_q;
   logic       mdc_rise;
   logic       bit_in;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mdc_s_q  <= 2'h0;
         mdio_s_q <= 2'h3;
         mdc_d_q  <= 1'b0;
      end else begin
         mdc_s_q  <= {mdc_s_q[0], lnk.mdc};
         mdio_s_q <= {mdio_s_q[0], lnk.mdio};
         mdc_d_q  <= mdc_s_q[1];
      end
   end

   assign mdc_rise = mdc_s_q[1] & ~mdc_d_q;
   assign bit_in   = mdio_s_q[1];

   // =====================================================================
   // Strap capture
   logic [3:0] strap_s1_q;
   logic [3:0] strap_s2_q;
   logic [1:0] strap_cnt_q;
   logic       strap_done_q;
   logic [2:0] port_hi_q;
   logic       order_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_s1_q   <= 4'h0;
         strap_s2_q   <= 4'h0;
         strap_cnt_q  <= 2'h0;
         strap_done_q <= 1'b0;
         port_hi_q    <= 3'h0;
         order_q      <= 1'b0;
      end else begin
         strap_s1_q <= {port_address_order, port_address_hi};
         strap_s2_q <= strap_s1_q;
         if (!strap_done_q) begin
            if (strap_cnt_q == STRAP_WAIT) begin
               port_hi_q    <= strap_s2_q[2:0];
               order_q      <= strap_s2_q[3];
               strap_done_q <= 1'b1;
            end else begin
               strap_cnt_q <= strap_cnt_q + 2'h1;
            end
         end
      end
   end

   // =====================================================================
   // Frame parser
   mdm_dev_state_t state_q;
   logic [4:0]     cnt_q;
   logic [11:0]    hdr_q;
   logic [12:0]    hdr_w;
   mdm_word_t      data_q;
   logic           hdr_done_q;
   logic           fr_end_q;

   assign hdr_w = {hdr_q, bit_in};

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q    <= S_IDLE;
         cnt_q      <= 5'h0;
         hdr_q      <= 12'h0;
         data_q     <= 16'h0;
         hdr_done_q <= 1'b0;
         fr_end_q   <= 1'b0;
      end else begin
         hdr_done_q <= 1'b0;
         fr_end_q   <= 1'b0;
         if (mdc_rise) begin
            case (state_q)
               S_IDLE: begin
                  cnt_q <= 5'h0;
                  if (!bit_in) begin
                     state_q <= S_HDR;
                  end
               end
               S_HDR: begin
                  hdr_q <= hdr_w[11:0];
                  cnt_q <= cnt_q + 5'h1;
                  if (cnt_q == HDR_LAST) begin
                     state_q    <= S_TA;
                     cnt_q      <= 5'h0;
                     hdr_done_q <= 1'b1;
                  end
               end
               S_TA: begin
                  cnt_q <= cnt_q + 5'h1;
                  if (cnt_q == 5'h1) begin
                     state_q <= S_DATA;
                     cnt_q   <= 5'h0;
                  end
               end
               S_DATA: begin
                  data_q <= {data_q[14:0], bit_in};
                  cnt_q  <= cnt_q + 5'h1;
                  if (cnt_q == DATA_LAST) begin
                     state_q  <= S_IDLE;
                     fr_end_q <= 1'b1;
                  end
               end
               default: begin
                  state_q <= S_IDLE;
               end
            endcase
         end
      end
   end

   // =====================================================================
   // Header decode and port matching
   logic       hdr_last;
   logic [4:0] pa_w;
   logic       leg_w;
   logic       rd_w;
   logic [3:0] full_m;
   logic [3:0] wr_m;
   logic       leg_q;
   logic [1:0] op_q;
   logic [4:0] ra_q;
   logic       is_read_q;
   logic [3:0] hit_q;
   mdm_word_t  page_q [4];
   mdm_word_t  ext_addr_q [4];

   assign hdr_last = mdc_rise & (state_q == S_HDR) & (cnt_q == HDR_LAST);
   assign pa_w     = hdr_w[9:5];
   assign leg_w    = hdr_w[12];
   assign rd_w     = leg_w ? (hdr_w[11:10] == OP_LEG_RD) : hdr_w[11];

   always_comb begin
      for (int p = 0; p < 4; p++) begin
         full_m[p] = strap_done_q & (pa_w == {port_hi_q, mdm_low_addr(2'(p), order_q)});
         wr_m[p] = strap_done_q
                   & (page_q[p][IGN_HI_BIT] | (pa_w[4:2] == port_hi_q))
                   & (page_q[p][IGN_LO_BIT] | (pa_w[1:0] == mdm_low_addr(2'(p), order_q)));
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         leg_q     <= 1'b0;
         op_q      <= 2'h0;
         ra_q      <= 5'h0;
         is_read_q <= 1'b0;
         hit_q     <= 4'h0;
      end else if (hdr_last) begin
         leg_q     <= leg_w;
         op_q      <= hdr_w[11:10];
         ra_q      <= hdr_w[4:0];
         is_read_q <= rd_w;
         hit_q     <= rd_w ? full_m : wr_m;
      end
   end

   // =====================================================================
   // Target resolution per port
   logic       ext_addr_op;
   logic [3:0] phit;
   mdm_word_t  regnum_p [4];
   logic [1:0] sp;

   assign ext_addr_op = ~leg_q & (op_q == OP_EXT_ADDR);
   assign sp          = mdm_first(hit_q);

   always_comb begin
      for (int p = 0; p < 4; p++) begin
         regnum_p[p] = leg_q ? {LEG_WIN_TAG, page_q[p][7:0], ra_q} : ext_addr_q[p];
         phit[p] = ~ext_addr_op & (leg_q ? (ra_q == PAGE_REG_NUM)
                   : ((ra_q == LEG_DEVAD) && (ext_addr_q[p][15:13] == LEG_WIN_TAG)
                      && (ext_addr_q[p][4:0] == PAGE_REG_NUM)));
      end
   end

   // =====================================================================
   // Page register, hard reset only
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int p = 0; p < 4; p++) begin
            page_q[p] <= PAGE_REG_RST;
         end
      end else if (fr_end_q && !is_read_q) begin
         for (int p = 0; p < 4; p++) begin
            // write stores bits 15:14 and 7:0
            if (hit_q[p] && phit[p]) begin
               page_q[p] <= data_q & PAGE_REG_WMASK;
            end
         end
      end
   end

   // Undefined after reset, so no reset term
   always_ff @(posedge core_clk) begin
      for (int p = 0; p < 4; p++) begin
         if (fr_end_q && ext_addr_op && hit_q[p]) begin
            ext_addr_q[p] <= data_q;
         end else if (fr_end_q && !leg_q && (op_q == OP_EXT_RDI) && hit_q[p]) begin
            ext_addr_q[p] <= ext_addr_q[p] + 16'h1;
         end
      end
   end

   // =====================================================================
   // Register access port
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_wr        <= 1'b0;
         acc_rd        <= 1'b0;
         acc_port_mask <= 4'h0;
         acc_devad     <= 5'h0;
         acc_regnum    <= 16'h0;
         acc_wdata     <= 16'h0;
      end else begin
         acc_rd <= hdr_done_q & is_read_q & (|(hit_q & ~phit));
         // one strobe covers all hit ports
         acc_wr <= fr_end_q & ~is_read_q & ~ext_addr_op & (|(hit_q & ~phit));
         if ((hdr_done_q && is_read_q) || (fr_end_q && !is_read_q)) begin
            acc_port_mask <= hit_q & ~phit;
            acc_devad     <= leg_q ? LEG_DEVAD : ra_q;
            acc_regnum    <= regnum_p[sp];
            acc_wdata     <= data_q;
         end
      end
   end

   // =====================================================================
   // Read drive, launched right after each sample edge
   mdm_word_t rdbuf_q;
   logic      oe_q;
   logic      o_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdbuf_q <= 16'h0;
         oe_q    <= 1'b0;
         o_q     <= 1'b1;
      end else if (mdc_rise) begin
         if (state_q == S_TA && cnt_q == 5'h0 && is_read_q && (|hit_q)) begin
            oe_q    <= 1'b1;
            o_q     <= 1'b0;
            rdbuf_q <= phit[sp] ? page_q[sp] : acc_rdata;
         end else if (oe_q && (state_q == S_TA || (state_q == S_DATA && cnt_q != DATA_LAST))) begin
            o_q     <= rdbuf_q[15];
            rdbuf_q <= {rdbuf_q[14:0], 1'b0};
         end else begin
            oe_q <= 1'b0;
            o_q  <= 1'b1;
         end
      end
   end

   assign lnk.dev_mdio_oe = oe_q;
   assign lnk.dev_mdio_o  = o_q;

   always_comb begin
      for (int p = 0; p < 4; p++) begin
         page_select_and_broadcast[p] = page_q[p];
      end
   end

endmodule
`default_nettype wire

// file: verilog/mdm_sta.sv
// Station end: APB-commanded management frame generator
`timescale 1ns/100ps
`default_nettype none
module mdm_sta #(
   parameter int MDC_HALF = 8
) (
   // Clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst_n,
   // Link
   mdm_if.station             lnk,
   // APB slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr
);
   import mdm_pkg::*;

   // =====================================================================
   // APB decode
   logic [14:0]     frame_q;
   mdm_pkg::mdm_word_t wdata_q;
   mdm_pkg::mdm_word_t rdata_q;
   logic            busy_q;
   logic            acc;
   logic            mapped;
   logic            start;

   assign acc     = psel & penable;
   assign mapped  = (paddr == REG_FRAME) | (paddr == REG_WDATA) | (paddr == REG_STATUS) | (paddr == REG_RDATA);
   assign pready  = 1'b1;
   // Frame write while busy is refused, not queued
   assign pslverr = acc & (~mapped | (pwrite & (paddr == REG_FRAME) & busy_q));
   assign start   = acc & pwrite & (paddr == REG_FRAME) & ~busy_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_q <= 15'h0;
         wdata_q <= 16'h0;
         prdata  <= 32'h0;
      end else begin
         if (start) begin
            frame_q <= pwdata[14:0];
         end
         if (acc && pwrite && paddr == REG_WDATA) begin
            wdata_q <= pwdata[15:0];
         end
         // Read data latched in setup phase
         if (psel && !penable) begin
            if (paddr == REG_FRAME) begin
               prdata <= {17'h0, frame_q};
            end else if (paddr == REG_WDATA) begin
               prdata <= {16'h0, wdata_q};
            end else if (paddr == REG_STATUS) begin
               prdata <= {31'h0, busy_q};
            end else if (paddr == REG_RDATA) begin
               prdata <= {16'h0, rdata_q};
            end else begin
               prdata <= 32'h0;
            end
         end
      end
   end

   // =====================================================================
   // Frame engine
   logic [1:0]  st_w;
   logic [1:0]  op_w;
   logic        rd_w;
   logic [31:0] hdr_w;
   logic [1:0]  mdio_s_q;
   logic [7:0]  div_q;
   logic        mdc_q;
   logic [63:0] sh_q;
   logic [6:0]  idx_q;
   logic [6:0]  nb_q;
   logic        rd_q;
   logic        oe_q;
   logic        tick;
   logic [6:0]  idx_n;

   assign st_w  = pwdata[FRM_ST_LSB +: 2];
   assign op_w  = pwdata[FRM_OP_LSB +: 2];
   assign rd_w  = (st_w == ST_LEGACY) ? (op_w == OP_LEG_RD) : op_w[1];
   assign hdr_w = {st_w, op_w, pwdata[FRM_PA_LSB +: 5], pwdata[FRM_RA_LSB +: 5],
                   rd_w ? TA_RELEASED : TA_DRIVEN, wdata_q};
   // half period is MDC_HALF cycles; not checked against MDC_HALF_MIN
   assign tick  = busy_q & (div_q == 8'(MDC_HALF - 1));
   assign idx_n = idx_q + 7'h1;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mdio_s_q <= 2'h3;
      end else begin
         mdio_s_q <= {mdio_s_q[0], lnk.mdio};
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q  <= 1'b0;
         div_q   <= 8'h0;
         mdc_q   <= 1'b0;
         sh_q    <= 64'h0;
         idx_q   <= 7'h0;
         nb_q    <= 7'h0;
         rd_q    <= 1'b0;
         oe_q    <= 1'b0;
         rdata_q <= 16'h0;
      end else if (start) begin
         busy_q <= 1'b1;
         div_q  <= 8'h0;
         mdc_q  <= 1'b0;
         idx_q  <= 7'h0;
         rd_q   <= rd_w;
         oe_q   <= 1'b1;
         if (pwdata[FRM_PRE_BIT]) begin
            sh_q <= {32'hffffffff, hdr_w};
            nb_q <= PRE_BITS + FRAME_BITS;
         end else begin
            sh_q <= {hdr_w, 32'h0};
            nb_q <= FRAME_BITS;
         end
      end else if (busy_q) begin
         div_q <= tick ? 8'h0 : div_q + 8'h1;
         if (tick) begin
            mdc_q <= ~mdc_q;
            if (!mdc_q) begin
               // Rising edge: capture read data
               if (rd_q && idx_q >= nb_q - DATA_BITS && idx_q < nb_q) begin
                  rdata_q <= {rdata_q[14:0], mdio_s_q[1]};
               end
            end else begin
               // Falling edge: launch next bit
               idx_q <= idx_n;
               sh_q  <= {sh_q[62:0], 1'b1};
               if (idx_n >= nb_q) begin
                  oe_q <= 1'b0;
               end else if (rd_q && idx_n >= nb_q - DATA_BITS - TA_BITS) begin
                  oe_q <= 1'b0;
               end
               if (idx_n == nb_q + 7'h1) begin
                  busy_q <= 1'b0;
               end
            end
         end
      end
   end

   assign lnk.mdc         = mdc_q;
   assign lnk.sta_mdio_o  = sh_q[63];
   assign lnk.sta_mdio_oe = oe_q;

endmodule
`default_nettype wire

// file: dv/mdm_monitor.sv
// Checker for the wire rules of the management link
`timescale 1ns/100ps
`default_nettype none
module mdm_monitor #(
   parameter int MDC_HALF = 4
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // Link
   input  wire logic mdc,
   input  wire logic sta_mdio_o,
   input  wire logic sta_mdio_oe,
   input  wire logic dev_mdio_o,
   input  wire logic dev_mdio_oe,
   input  wire logic mdio
);
   import mdm_pkg::*;
   localparam int DRV_LEN = 34 * MDC_HALF;
   logic [8:0] drv_q;
   logic [8:0] idle_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // ==========================================
   // Helper counters
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         drv_q <= 9'h000;
      end else begin
         drv_q <= dev_mdio_oe ? drv_q + 9'h001 : 9'h000;
      end
   end

   // Saturates so long quiet spells never wrap
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_q <= 9'h000;
      end else if (sta_mdio_oe || dev_mdio_oe) begin
         idle_q <= 9'h000;
      end else if (idle_q != 9'h1ff) begin
         idle_q <= idle_q + 9'h001;
      end
   end

   // ==========================================
   // Assertions
   sequence ta_zero;
      !dev_mdio_o && !sta_mdio_oe;
   endsequence

   // Repetition counts match MDC_HALF of 4
   a_mdc_high_min: assert property ($rose(mdc) |-> mdc[*4])
      else $error("link clock high phase too short");
   a_mdc_low_min: assert property ($fell(mdc) |-> !mdc[*4])
      else $error("link clock low phase too short");
   a_one_driver: assert property (!(sta_mdio_oe && dev_mdio_oe))
      else $error("both ends drive the data line");
   a_ta_zero_first: assert property ($rose(dev_mdio_oe) |-> ta_zero)
      else $error("device turnaround bit not zero");
   a_sta_released: assert property ($rose(dev_mdio_oe) |-> !$past(sta_mdio_oe, 6))
      else $error("station still driving before device turnaround");
   a_read_length: assert property ($fell(dev_mdio_oe) |-> drv_q >= DRV_LEN - 1 && drv_q <= DRV_LEN + 1)
      else $error("device drove the line for a wrong span");
   a_dev_stable_rise: assert property ($rose(mdc) |-> $stable(dev_mdio_o) && $stable(dev_mdio_oe))
      else $error("device data moved at link clock rise");
   a_sta_stable_rise: assert property ($rose(mdc) |-> $stable(sta_mdio_o) && $stable(sta_mdio_oe))
      else $error("station data moved at link clock rise");
   a_idle_gap: assert property ($rose(sta_mdio_oe) |-> idle_q >= 2 * MDC_HALF)
      else $error("no idle bit between frames");
endmodule
`default_nettype wire

// file: dv/mdm_tb.sv
// Bench joining station and device ends, commanded over APB
`timescale 1ns/100ps
`default_nettype none
module mdm_tb;
   import mdm_pkg::*;
   localparam int HALF = 4;
   logic             core_clk = 1'b0;
   logic             rst_n = 1'b0;
   logic             psel = 1'b0;
   logic             penable = 1'b0;
   logic             pwrite = 1'b0;
   logic [7:0]       paddr = 8'h00;
   logic [31:0]      pwdata = 32'h0;
   logic [31:0]      prdata;
   logic             pready;
   logic             pslverr;
   logic [2:0]       pa_hi = 3'h3;
   logic             order = 1'b0;
   logic             acc_wr;
   logic             acc_rd;
   logic [3:0]       acc_port_mask;
   logic [4:0]       acc_devad;
   mdm_word_t        acc_regnum;
   mdm_word_t        acc_wdata;
   mdm_word_t        acc_rdata = 16'h0000;
   mdm_word_t [3:0]  pages;
   logic [13:0]      cap_q = 14'h0;
   logic [31:0]      r;
   logic             e;
   int               n_errors = 0;
   int               n_tests = 0;
   int               n_wr = 0;

   mdm_if lnk_if();
   mdm_sta #(.MDC_HALF(HALF)) mdm_sta_inst (.core_clk(core_clk), .rst_n(rst_n), .lnk(lnk_if), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   mdm_dev mdm_dev_inst (.core_clk(core_clk), .rst_n(rst_n), .lnk(lnk_if), .port_address_hi(pa_hi),
      .port_address_order(order), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_port_mask(acc_port_mask),
      .acc_devad(acc_devad), .acc_regnum(acc_regnum), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
      .page_select_and_broadcast(pages));
   mdm_monitor #(.MDC_HALF(HALF)) mdm_monitor_inst (.core_clk(core_clk), .rst_n(rst_n), .mdc(lnk_if.mdc),
      .sta_mdio_o(lnk_if.sta_mdio_o), .sta_mdio_oe(lnk_if.sta_mdio_oe), .dev_mdio_o(lnk_if.dev_mdio_o),
      .dev_mdio_oe(lnk_if.dev_mdio_oe), .mdio(lnk_if.mdio));

   initial begin
      forever #5 core_clk = ~core_clk;
   end

   // Register file stand-in: data tied to the address it was asked for
   always @(posedge core_clk) begin
      if (acc_rd) acc_rdata <= acc_regnum ^ 16'ha5a5;
      if (acc_wr) n_wr++;
   end

   // Keeps the last 14 bits the station drove
   always @(posedge lnk_if.mdc) begin
      if (lnk_if.sta_mdio_oe) cap_q <= {cap_q[12:0], lnk_if.mdio};
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic frm(input logic [1:0] st, input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] d, input logic pre);
      apb(1'b1, REG_WDATA, {16'h0, d});
      apb(1'b1, REG_FRAME, {17'h0, pre, ra, pa, op, st});
      r = 32'h1;
      while (r[STS_BUSY] !== 1'b0) apb(1'b0, REG_STATUS, 32'h0);
      apb(1'b0, REG_RDATA, 32'h0);
   endtask

   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Roughly 25 frames of under 1000 cycles each
   initial begin
      #400us;
      n_errors++;
      end_sim;
   end

   initial begin
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (12) @(posedge core_clk);
      frm(ST_LEGACY, OP_LEG_RD, 5'h0c, PAGE_REG_NUM, 16'h0, 1'b0);
      chk(r, 0);
      chk(cap_q, {ST_LEGACY, OP_LEG_RD, 5'h0c, PAGE_REG_NUM});
      frm(ST_LEGACY, OP_LEG_WR, 5'h0d, PAGE_REG_NUM, 16'h3f05, 1'b0);
      frm(ST_LEGACY, OP_LEG_RD, 5'h0d, PAGE_REG_NUM, 16'h0, 1'b1);
      chk(r, 16'h0005);
      frm(ST_LEGACY, OP_LEG_WR, 5'h10, PAGE_REG_NUM, 16'h0077, 1'b0);
      chk(pages, {16'h0, 16'h0, 16'h0005, 16'h0});
      frm(ST_LEGACY, OP_LEG_RD, 5'h0d, 5'h04, 16'h0, 1'b0);
      chk(r, {3'h4, 8'h05, 5'h04} ^ 16'ha5a5);
      chk(acc_devad, LEG_DEVAD);
      for (int p = 0; p < 4; p++) frm(ST_LEGACY, OP_LEG_WR, 5'(12 + p), PAGE_REG_NUM, 16'h4002, 1'b0);
      frm(ST_LEGACY, OP_LEG_WR, 5'h0c, PAGE_REG_NUM, 16'h4009, 1'b0);
      chk(pages, {4{16'h4009}});
      frm(ST_LEGACY, OP_LEG_WR, 5'h0c, 5'h03, 16'h1234, 1'b0);
      chk({acc_port_mask, acc_wdata}, {4'hf, 16'h1234});
      frm(ST_LEGACY, OP_LEG_RD, 5'h0d, 5'h03, 16'h0, 1'b0);
      chk(acc_port_mask, 4'h2);
      frm(ST_LEGACY, OP_LEG_WR, 5'h0c, PAGE_REG_NUM, 16'h0001, 1'b0);
      frm(ST_LEGACY, OP_LEG_WR, 5'h0d, PAGE_REG_NUM, 16'h0003, 1'b0);
      chk(pages, {16'h0001, 16'h0001, 16'h0003, 16'h0001});
      frm(ST_EXT, OP_EXT_ADDR, 5'h0c, LEG_DEVAD, 16'h8031, 1'b0);
      frm(ST_EXT, OP_EXT_RD, 5'h0c, LEG_DEVAD, 16'h0, 1'b0);
      chk(r, 16'h8031 ^ 16'ha5a5);
      frm(ST_EXT, OP_EXT_RDI, 5'h0c, LEG_DEVAD, 16'h0, 1'b0);
      chk(r, 16'h8031 ^ 16'ha5a5);
      frm(ST_EXT, OP_EXT_RDI, 5'h0c, LEG_DEVAD, 16'h0, 1'b0);
      chk(r, 16'h8032 ^ 16'ha5a5);
      frm(ST_EXT, OP_EXT_WR, 5'h0c, LEG_DEVAD, 16'hbeef, 1'b0);
      chk({acc_regnum, acc_wdata}, {16'h8033, 16'hbeef});
      frm(ST_EXT, OP_EXT_RD, 5'h0c, LEG_DEVAD, 16'h0, 1'b0);
      chk(r, 16'h8033 ^ 16'ha5a5);
      frm(ST_LEGACY, OP_LEG_WR, 5'h0c, PAGE_REG_NUM, 16'h8000, 1'b0);
      frm(ST_LEGACY, OP_LEG_WR, 5'h10, 5'h03, 16'h5678, 1'b0);
      chk({acc_port_mask, acc_wdata}, {4'h1, 16'h5678});
      chk(n_wr, 3);
      apb(1'b0, 8'h10, 32'h0);
      chk(e, 1'b1);
      @(posedge core_clk);
      rst_n <= 1'b0;
      order <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk(pages, 64'h0);
      rst_n <= 1'b1;
      repeat (12) @(posedge core_clk);
      frm(ST_LEGACY, OP_LEG_WR, 5'h0f, PAGE_REG_NUM, 16'h0011, 1'b0);
      chk(pages, {48'h0, 16'h0011});
      end_sim;
   end
endmodule
`default_nettype wire
